// ===== vact_top.sv
// Purpose: Processor registers and display memory transfer engine of a video terminal controller
// Assumes: Strobes synchronous to i_sys_clk; display memory read data valid while re stands
// Notes: Transfers to display memory wait for i_blank, the retrace blanking level
// How it works
// - Status row shown when its enable bit is one, blank otherwise.
// - Cursor-high byte holds scroll offset and cursor address bits ten to eight.
// - Each stored character carries a tag bit gating shared attributes.
// - Attributes applied at display time, so one change alters every tagged character in alpha kind.
// - Cursor, screen and mode bits act regardless of the tag.
// - Alpha kind applies the four attributes only to tagged characters.
// - Graphics kind shows tagged as plain alphanumerics, untagged as graphics.
// - Bits blank, brighten, underline and reverse a tagged character.
// - Cursor suppress, underline or block cursor, and white screen select.
// - Port byte is tag in top bit plus seven-bit code.
// - Byte and kind select pick font glyph, wide or thin graphics.
// - Auto increment bit advances transfer address after each processor transfer.
// - Auto increment never moves the visible cursor.
// - Byte write stores the port character at the transfer address, loaded from the cursor.
// - Port read fetches the transfer-address character; next read returns it.
// - Armed fill turns the next port write into a fill.
// - Memory transfers happen only during retrace blanking.
// - Done clears on port access, sets when transfer or fill finishes.
// - Fill writes from cursor up to, not including, fill end; cursor kept.
module vact_top (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Processor bus
   input wire logic i_addr_sel,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_db,
   output logic [7:0] o_db,
   output logic o_db_oe,
   // Display memory
   input wire logic i_blank,
   input wire logic [7:0] i_dm_rdata,
   output vact_pkg::vact_dm_req_t o_dm,
   // Raster side inputs
   input wire logic [7:0] i_disp_char,
   input wire logic i_font_dot,
   input wire logic i_gfx_dot,
   input wire logic i_underline_row,
   input wire logic i_cursor_here,
   input wire logic i_status_row,
   // Raster side setup and video
   output logic [10:0] o_cursor_addr,
   output logic [3:0] o_scroll_line_offset,
   output logic o_status_row_enable,
   output logic o_display_kind_select,
   output logic o_video,
   output logic o_bright_level_output,
   output logic [1:0] o_glyph_kind
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic rd_prev_ff;
   logic wr_prev_ff;
   logic [3:0] addr_ff;
   logic [7:0] cursor_low_byte_ff;
   logic [7:0] cursor_high_byte_ff;
   logic [7:0] fill_end_pointer_ff;
   logic [7:0] attribute_setup_ff;
   logic [7:0] xfer_opt_ff;
   logic [7:0] char_ff;
   logic [7:0] db_ff;
   logic done_ff;
   logic fill_armed_ff;
   logic [10:0] xfer_addr_ff;
   logic [10:0] fill_addr_ff;
   vact_pkg::vact_state_t state_ff;
   vact_pkg::vact_dm_req_t dm_ff;

   logic rd_start;
   logic wr_start;
   logic data_wr;
   logic data_rd;
   logic char_wr;
   logic char_rd;
   logic cur_lo_wr;
   logic cur_hi_wr;
   logic auto_inc;
   logic [10:0] fill_end;
   logic [10:0] new_cursor;
   logic [7:0] rd_mux;

   logic [7:0] nxt_char;
   logic [10:0] nxt_xfer;
   logic [10:0] nxt_fill;
   logic nxt_done;
   logic nxt_armed;
   logic done_set;
   vact_pkg::vact_state_t nxt_state;
   vact_pkg::vact_dm_req_t nxt_dm;

   // ----------------------------------------
   // Processor access decode
   // ----------------------------------------

   // One-cycle access events at the leading edge of each strobe
   assign rd_start = !i_rd_n && rd_prev_ff;
   assign wr_start = !i_wr_n && wr_prev_ff;
   assign data_wr = wr_start && !i_addr_sel;
   assign data_rd = rd_start && !i_addr_sel;
   assign char_wr = data_wr && (addr_ff == vact_pkg::REG_CHAR_PORT);
   assign char_rd = data_rd && (addr_ff == vact_pkg::REG_CHAR_PORT);
   assign cur_lo_wr = data_wr && (addr_ff == vact_pkg::REG_CURSOR_LOW);
   assign cur_hi_wr = data_wr && (addr_ff == vact_pkg::REG_CURSOR_HIGH);

   // Field views
   assign auto_inc = xfer_opt_ff[vact_pkg::OPT_AUTO_INC];
   assign o_cursor_addr = {cursor_high_byte_ff[vact_pkg::HI_ADDR_MSB:0], cursor_low_byte_ff};
   assign o_scroll_line_offset = cursor_high_byte_ff[vact_pkg::HI_SCROLL_MSB:vact_pkg::HI_SCROLL_LSB];
   assign o_status_row_enable = cursor_high_byte_ff[vact_pkg::HI_STATUS_ROW];
   assign o_display_kind_select = attribute_setup_ff[vact_pkg::AT_KIND];
   assign fill_end = {fill_end_pointer_ff[6:0], vact_pkg::FILL_LOW_BITS};
   assign new_cursor = cur_lo_wr ? {cursor_high_byte_ff[vact_pkg::HI_ADDR_MSB:0], i_db} :
                       {i_db[vact_pkg::HI_ADDR_MSB:0], cursor_low_byte_ff};

   // Status read or character port read, others read zero
   assign rd_mux = i_addr_sel ? {done_ff, 7'h00} :
                   (addr_ff == vact_pkg::REG_CHAR_PORT) ? char_ff : vact_pkg::RST_BYTE;
   assign o_db = db_ff;
   assign o_db_oe = !i_rd_n;
   assign o_dm = dm_ff;

   // ----------------------------------------
   // Transfer engine
   // ----------------------------------------

   // Next state, memory request, addresses and port byte
   always_comb begin
      nxt_state = state_ff;
      nxt_dm = '0;
      nxt_char = char_ff;
      nxt_xfer = xfer_addr_ff;
      nxt_fill = fill_addr_ff;
      nxt_armed = fill_armed_ff;
      done_set = 1'b0;
      unique case (state_ff)
         vact_pkg::ST_IDLE: begin
            if (char_wr) begin
               nxt_char = i_db;
               if (fill_armed_ff) begin
                  nxt_state = vact_pkg::ST_FILL;
                  nxt_fill = o_cursor_addr;
                  nxt_armed = 1'b0;
               end else begin
                  nxt_state = vact_pkg::ST_WRITE;
               end
            end else if (char_rd) begin
               nxt_state = vact_pkg::ST_READ;
            end
         end
         vact_pkg::ST_WRITE: begin
            if (i_blank) begin
               nxt_dm.we = 1'b1;
               nxt_dm.addr = xfer_addr_ff;
               nxt_dm.wdata = char_ff;
               nxt_xfer = auto_inc ? xfer_addr_ff + vact_pkg::ADDR_STEP : xfer_addr_ff;
               done_set = 1'b1;
               nxt_state = vact_pkg::ST_IDLE;
            end
         end
         vact_pkg::ST_READ: begin
            if (i_blank) begin
               nxt_dm.re = 1'b1;
               nxt_dm.addr = xfer_addr_ff;
               nxt_state = vact_pkg::ST_READ_CAP;
            end
         end
         vact_pkg::ST_READ_CAP: begin
            nxt_char = i_dm_rdata;
            nxt_xfer = auto_inc ? xfer_addr_ff + vact_pkg::ADDR_STEP : xfer_addr_ff;
            done_set = 1'b1;
            nxt_state = vact_pkg::ST_IDLE;
         end
         vact_pkg::ST_FILL: begin
            if (fill_addr_ff == fill_end) begin
               done_set = 1'b1;
               nxt_state = vact_pkg::ST_IDLE;
            end else if (i_blank) begin
               nxt_dm.we = 1'b1;
               nxt_dm.addr = fill_addr_ff;
               nxt_dm.wdata = char_ff;
               nxt_fill = fill_addr_ff + vact_pkg::ADDR_STEP;
            end
         end
         default: begin
            nxt_state = vact_pkg::ST_IDLE;
         end
      endcase
      // Cursor load resets the transfer position
      if (cur_lo_wr || cur_hi_wr) begin
         nxt_xfer = new_cursor;
      end
      // Fill end write arms the fill
      if (data_wr && (addr_ff == vact_pkg::REG_FILL_END)) begin
         nxt_armed = 1'b1;
      end
   end

   // Done flag: set wins over clear; chip reset sets it
   assign nxt_done = (done_set || (data_wr && (addr_ff == vact_pkg::REG_CHIP_RESET))) ? 1'b1 :
                     (char_wr || char_rd) ? 1'b0 : done_ff;

   // Strobe history, address register and read data
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_prev_ff <= 1'b1;
         wr_prev_ff <= 1'b1;
         addr_ff <= vact_pkg::RST_ADDR_REG;
         db_ff <= vact_pkg::RST_BYTE;
      end else begin
         rd_prev_ff <= i_rd_n;
         wr_prev_ff <= i_wr_n;
         if (wr_start && i_addr_sel) begin
            addr_ff <= i_db[3:0];
         end
         if (rd_start) begin
            db_ff <= rd_mux;
         end
      end
   end

   // Setup registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         cursor_low_byte_ff <= vact_pkg::RST_BYTE;
         cursor_high_byte_ff <= vact_pkg::RST_BYTE;
         fill_end_pointer_ff <= vact_pkg::RST_BYTE;
         attribute_setup_ff <= vact_pkg::RST_BYTE;
         xfer_opt_ff <= vact_pkg::RST_BYTE;
      end else if (data_wr) begin
         if (addr_ff == vact_pkg::REG_CURSOR_LOW) cursor_low_byte_ff <= i_db;
         if (addr_ff == vact_pkg::REG_CURSOR_HIGH) cursor_high_byte_ff <= i_db;
         if (addr_ff == vact_pkg::REG_FILL_END) fill_end_pointer_ff <= i_db;
         if (addr_ff == vact_pkg::REG_ATTRIBUTE) attribute_setup_ff <= i_db;
         if (addr_ff == vact_pkg::REG_XFER_OPT) xfer_opt_ff <= i_db;
      end
   end

   // Engine registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff <= vact_pkg::ST_IDLE;
         dm_ff <= '0;
         char_ff <= vact_pkg::RST_BYTE;
         xfer_addr_ff <= vact_pkg::RST_DM_ADDR;
         fill_addr_ff <= vact_pkg::RST_DM_ADDR;
         done_ff <= vact_pkg::RST_DONE;
         fill_armed_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         dm_ff <= nxt_dm;
         char_ff <= nxt_char;
         xfer_addr_ff <= nxt_xfer;
         fill_addr_ff <= nxt_fill;
         done_ff <= nxt_done;
         fill_armed_ff <= nxt_armed;
      end
   end

   // ----------------------------------------
   // Display-time dot gating
   // ----------------------------------------
   vact_pixel u_pixel (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_attr(attribute_setup_ff),
      .i_status_row_enable(o_status_row_enable),
      .i_char(i_disp_char),
      .i_font_dot(i_font_dot),
      .i_gfx_dot(i_gfx_dot),
      .i_underline_row(i_underline_row),
      .i_cursor_here(i_cursor_here),
      .i_status_row(i_status_row),
      .i_blank(i_blank),
      .o_video(o_video),
      .o_bright_level_output(o_bright_level_output),
      .o_glyph_kind(o_glyph_kind)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_DONE_CLEARED: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (char_wr && state_ff == vact_pkg::ST_IDLE) |=> !done_ff && state_ff != vact_pkg::ST_IDLE)
      else $error("done not cleared by port write");

   AST_MEM_IN_BLANK: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (o_dm.we || o_dm.re) |-> $past(i_blank))
      else $error("memory access outside blanking");

   AST_BYTE_STORE: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == vact_pkg::ST_WRITE && i_blank)
      |=> o_dm.we && o_dm.addr == $past(xfer_addr_ff) && o_dm.wdata == $past(char_ff) && done_ff)
      else $error("byte store wrong");

   AST_AUTO_INC: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == vact_pkg::ST_WRITE && i_blank && !cur_lo_wr && !cur_hi_wr)
      |=> xfer_addr_ff == $past(xfer_addr_ff) + ($past(auto_inc) ? 11'h001 : 11'h000))
      else $error("transfer address step wrong");

   AST_CURSOR_KEPT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state_ff != vact_pkg::ST_IDLE && !data_wr) |=> $stable(o_cursor_addr))
      else $error("cursor moved by transfer");

   AST_READ_FETCH: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == vact_pkg::ST_READ && i_blank)
      |=> o_dm.re ##1 (char_ff == $past(i_dm_rdata) && done_ff))
      else $error("read fetch did not load port");

   AST_FILL_START: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (char_wr && fill_armed_ff && state_ff == vact_pkg::ST_IDLE)
      |=> state_ff == vact_pkg::ST_FILL && fill_addr_ff == $past(o_cursor_addr))
      else $error("armed write did not start fill");

   AST_FILL_STOP: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state_ff == vact_pkg::ST_FILL && fill_addr_ff == fill_end)
      |=> !o_dm.we && done_ff && state_ff == vact_pkg::ST_IDLE)
      else $error("fill wrote past its end");

endmodule

// ===== vact_pkg.sv
// Purpose: Shared constants and types for the video attribute and character transfer block
// Assumes: Eight-bit processor bus, eleven-bit display memory address
// Notes: Register indexes are the low four bits of the address register
package vact_pkg;

   // ----------------------------------------
   // Register indexes
   // ----------------------------------------
   localparam logic [3:0] REG_CHIP_RESET = 4'h6;
   localparam logic [3:0] REG_TOP_SCREEN = 4'h8;
   localparam logic [3:0] REG_CURSOR_LOW = 4'h9;
   localparam logic [3:0] REG_CURSOR_HIGH = 4'hA;
   localparam logic [3:0] REG_FILL_END = 4'hB;
   localparam logic [3:0] REG_ATTRIBUTE = 4'hC;
   localparam logic [3:0] REG_CHAR_PORT = 4'hD;
   localparam logic [3:0] REG_XFER_OPT = 4'hE;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int HI_STATUS_ROW = 7;
   localparam int HI_SCROLL_MSB = 6;
   localparam int HI_SCROLL_LSB = 3;
   localparam int HI_ADDR_MSB = 2;
   localparam int AT_KIND = 7;
   localparam int AT_CUR_SUPPRESS = 6;
   localparam int AT_CUR_UNDERLINE = 5;
   localparam int AT_WHITE_SCREEN = 4;
   localparam int AT_CHAR_BLANK = 3;
   localparam int AT_BRIGHT = 2;
   localparam int AT_UNDERLINE = 1;
   localparam int AT_REVERSE = 0;
   localparam int OPT_AUTO_INC = 7;
   localparam int CH_TAG = 7;
   localparam int CH_WIDE = 6;
   localparam int ST_DONE = 7;

   // ----------------------------------------
   // Reset values and steps
   // ----------------------------------------
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_ADDR_REG = 4'h0;
   localparam logic [10:0] RST_DM_ADDR = 11'h000;
   localparam logic RST_DONE = 1'b1;
   localparam logic [10:0] ADDR_STEP = 11'h001;
   localparam logic [3:0] FILL_LOW_BITS = 4'h0;

   // ----------------------------------------
   // Glyph kinds handed to the font logic
   // ----------------------------------------
   localparam logic [1:0] GLYPH_FONT = 2'h0;
   localparam logic [1:0] GLYPH_WIDE = 2'h1;
   localparam logic [1:0] GLYPH_THIN = 2'h2;

   // ----------------------------------------
   // Transfer engine states, Gray along the path
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_WRITE = 3'h1,
      ST_FILL = 3'h3,
      ST_READ = 3'h2,
      ST_READ_CAP = 3'h6
   } vact_state_t;

   // ----------------------------------------
   // Display memory request
   // ----------------------------------------
   typedef struct packed {
      logic we;
      logic re;
      logic [10:0] addr;
      logic [7:0] wdata;
   } vact_dm_req_t;

endpackage

// ===== vact_pixel.sv
// Purpose: Display-time attribute, mode and cursor gating of one dot
// Assumes: Font and graphics dots arrive already formed by the raster logic
// Notes: Outputs are registered, one cycle after the dot inputs
module vact_pixel (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Setup
   input wire logic [7:0] i_attr,
   input wire logic i_status_row_enable,
   // Current character and dot
   input wire logic [7:0] i_char,
   input wire logic i_font_dot,
   input wire logic i_gfx_dot,
   input wire logic i_underline_row,
   input wire logic i_cursor_here,
   input wire logic i_status_row,
   input wire logic i_blank,
   // Video out
   output logic o_video,
   output logic o_bright_level_output,
   output logic [1:0] o_glyph_kind
);

   logic tag;
   logic kind;
   logic attr_on;
   logic graphic;
   logic dot_raw;
   logic dot_attr;
   logic bg_level;
   logic vid_char;
   logic vid_cur;
   logic vid_final;
   logic bright;
   logic [1:0] glyph;
   logic video_ff;
   logic bright_ff;
   logic [1:0] glyph_ff;

   // Tag and mode decode
   assign tag = i_char[vact_pkg::CH_TAG];
   assign kind = i_attr[vact_pkg::AT_KIND];
   assign attr_on = !kind && tag;
   assign graphic = kind && !tag;
   assign glyph = !graphic ? vact_pkg::GLYPH_FONT :
                  i_char[vact_pkg::CH_WIDE] ? vact_pkg::GLYPH_WIDE : vact_pkg::GLYPH_THIN;

   // Character attributes from the shared setup at display time
   assign dot_raw = graphic ? i_gfx_dot : i_font_dot;
   assign dot_attr = (attr_on && i_attr[vact_pkg::AT_UNDERLINE] && i_underline_row) ||
                     (dot_raw && !(attr_on && i_attr[vact_pkg::AT_CHAR_BLANK]));
   assign bg_level = i_attr[vact_pkg::AT_WHITE_SCREEN] ^ (attr_on && i_attr[vact_pkg::AT_REVERSE]);
   assign vid_char = dot_attr ? !bg_level : bg_level;
   assign bright = attr_on && i_attr[vact_pkg::AT_BRIGHT];

   // Cursor presentation, independent of the tag
   assign vid_cur = !i_cursor_here ? vid_char :
                    i_attr[vact_pkg::AT_CUR_SUPPRESS] ? bg_level :
                    i_attr[vact_pkg::AT_CUR_UNDERLINE] ? (vid_char ^ i_underline_row) : !vid_char;

   // Blanking and disabled status row
   assign vid_final = i_blank ? 1'b0 :
                      (i_status_row && !i_status_row_enable) ? i_attr[vact_pkg::AT_WHITE_SCREEN] : vid_cur;

   // Output registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         video_ff <= 1'b0;
         bright_ff <= 1'b0;
         glyph_ff <= vact_pkg::GLYPH_FONT;
      end else begin
         video_ff <= vid_final;
         bright_ff <= bright && !i_blank && !(i_status_row && !i_status_row_enable);
         glyph_ff <= glyph;
      end
   end

   assign o_video = video_ff;
   assign o_bright_level_output = bright_ff;
   assign o_glyph_kind = glyph_ff;

   AST_GFX_NO_BRIGHT: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      graphic |=> !o_bright_level_output)
      else $error("graphics character drove the bright output");

   AST_ROW_BLANKED: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_status_row && !i_status_row_enable && !i_blank) |=> o_video == $past(i_attr[vact_pkg::AT_WHITE_SCREEN]))
      else $error("disabled status row not shown blank");

endmodule

// ===== vact_mem_model.sv
// Purpose: Display memory model facing the transfer engine
// Assumes: Read data must stand while the read pulse does, ahead of the capturing edge
// Notes: A released data bus shows the inverse of its last value
module vact_mem_model (
   // Clock
   input wire logic i_sys_clk,
   // Memory request and data
   input wire vact_pkg::vact_dm_req_t i_dm,
   output logic [7:0] o_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:2047];
   logic [7:0] last_ff;
   // Known fill pattern
   initial begin
      last_ff = 8'h00;
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 8'hE5;
      end
   end
   // Store writes, remember the last byte read
   always @(posedge i_sys_clk) begin
      if (i_dm.we === 1'b1) begin
         mem[i_dm.addr] <= i_dm.wdata;
      end
      if (i_dm.re === 1'b1) begin
         last_ff <= mem[i_dm.addr];
      end
   end
   // Read data stands with the read pulse, released bus shows the inverse
   assign o_rdata = (i_dm.re === 1'b1) ? mem[i_dm.addr] : ~last_ff;
endmodule

// ===== video_attribute_char_transfer_tb_top.sv
// Purpose: Self-checking bench of the register, gating and transfer block
// Assumes: Processor strobes driven at rising edges
// Notes: Nothing printed but mismatches and the verdict
module video_attribute_char_transfer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, sel, rd_n, wr_n, blank, fd, gd, ul, cur, srow, q_oe, sre, kind, vid, brt;
   logic [7:0] db, q, rdat, dch;
   logic [10:0] caddr;
   logic [3:0] scr;
   logic [1:0] gly;
   vact_pkg::vact_dm_req_t dm;
   int bad_count = 0;
   int checks = 0;
   int stray = 0;
   logic b1 = 1'b0;
   // Design and memory
   vact_top u_vact_top (.i_sys_clk(clk), .i_rst(rst), .i_addr_sel(sel), .i_rd_n(rd_n), .i_wr_n(wr_n),
      .i_db(db), .o_db(q), .o_db_oe(q_oe), .i_blank(blank), .i_dm_rdata(rdat), .o_dm(dm),
      .i_disp_char(dch), .i_font_dot(fd), .i_gfx_dot(gd), .i_underline_row(ul), .i_cursor_here(cur),
      .i_status_row(srow), .o_cursor_addr(caddr), .o_scroll_line_offset(scr), .o_status_row_enable(sre),
      .o_display_kind_select(kind), .o_video(vid), .o_bright_level_output(brt), .o_glyph_kind(gly));
   vact_mem_model u_vact_mem_model (.i_sys_clk(clk), .i_dm(dm), .o_rdata(rdat));
   // Clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Count memory pulses not launched from a blank cycle
   always @(posedge clk) begin
      #1;
      if ((dm.we | dm.re) === 1'b1 && b1 !== 1'b1) stray++;
      b1 = blank;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic s, input logic [7:0] d);
      @(posedge clk);
      sel <= s;
      db <= d;
      wr_n <= 1'b0;
      @(posedge clk);
      wr_n <= 1'b1;
      @(posedge clk);
   endtask
   task automatic rd(input logic s, output logic [7:0] d);
      @(posedge clk);
      sel <= s;
      rd_n <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      chk("bus_drive", {15'h0, q_oe}, 16'h1);
      rd_n <= 1'b1;
      #1;
      d = q;
      @(posedge clk);
   endtask
   task automatic setr(input logic [3:0] a, input logic [7:0] d);
      wr(1'b1, {4'h0, a});
      wr(1'b0, d);
   endtask
   task automatic wait_done();
      logic [7:0] s;
      for (int i = 0; i < 64; i++) begin
         rd(1'b1, s);
         if (s[7] === 1'b1) return;
      end
      chk("done_wait", 16'h0, 16'h1);
   endtask
   task automatic pix(input logic [7:0] at, input logic [7:0] ch, input logic [4:0] dots, input logic [3:0] e);
      setr(vact_pkg::REG_ATTRIBUTE, at);
      @(posedge clk);
      dch <= ch;
      {fd, gd, ul, cur, srow} <= dots;
      @(posedge clk);
      #1;
      chk("video_bright_glyph", {12'h0, vid, brt, gly}, {12'h0, e});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [7:0] s;
      rd(1'b1, s);
      chk("status_reset", {8'h0, s}, 16'h0080);
      setr(vact_pkg::REG_CURSOR_HIGH, 8'hFA);
      setr(vact_pkg::REG_CURSOR_LOW, 8'h5C);
      chk("status_row_enable", {15'h0, sre}, 16'h1);
      chk("scroll_offset", {12'h0, scr}, 16'h000F);
      chk("cursor_addr", {5'h0, caddr}, 16'h025C);
      setr(vact_pkg::REG_CURSOR_HIGH, 8'h00);
      wr(1'b1, {4'h0, vact_pkg::REG_TOP_SCREEN});
      rd(1'b0, s);
      chk("unmapped_read", {8'h0, s}, 16'h0000);
   endtask
   task automatic t_pixel();
      pix(8'h00, 8'hC1, 5'h10, 4'h8);
      pix(8'h01, 8'hC1, 5'h00, 4'h8);
      pix(8'h01, 8'h41, 5'h00, 4'h0);
      pix(8'h04, 8'hC1, 5'h10, 4'hC);
      pix(8'h04, 8'h41, 5'h10, 4'h8);
      pix(8'h08, 8'hC1, 5'h10, 4'h0);
      pix(8'h02, 8'hC1, 5'h04, 4'h8);
      pix(8'h02, 8'h41, 5'h04, 4'h0);
      pix(8'h10, 8'h41, 5'h00, 4'h8);
      pix(8'h10, 8'h41, 5'h10, 4'h0);
      pix(8'h40, 8'h41, 5'h12, 4'h0);
      pix(8'h00, 8'h41, 5'h02, 4'h8);
      pix(8'h20, 8'h41, 5'h02, 4'h0);
      pix(8'h20, 8'h41, 5'h06, 4'h8);
      pix(8'h80, 8'h40, 5'h08, 4'h9);
      pix(8'h80, 8'h00, 5'h08, 4'hA);
      pix(8'h81, 8'hC1, 5'h00, 4'h0);
      pix(8'h85, 8'hC1, 5'h10, 4'h8);
      chk("kind_select", {15'h0, kind}, 16'h1);
      pix(8'h00, 8'h41, 5'h11, 4'h0);
      @(posedge clk);
      {fd, gd, ul, cur, srow} <= 5'h00;
   endtask
   task automatic t_write();
      logic [7:0] s;
      setr(vact_pkg::REG_XFER_OPT, 8'h80);
      setr(vact_pkg::REG_CURSOR_HIGH, 8'h01);
      setr(vact_pkg::REG_CURSOR_LOW, 8'h23);
      setr(vact_pkg::REG_CHAR_PORT, 8'h41);
      repeat (8) @(posedge clk);
      rd(1'b1, s);
      chk("done_held_off", {8'h0, s}, 16'h0000);
      blank <= 1'b1;
      wait_done();
      wr(1'b0, 8'h42);
      wait_done();
      chk("mem_first", {8'h0, u_vact_mem_model.mem[11'h123]}, 16'h0041);
      chk("mem_next", {8'h0, u_vact_mem_model.mem[11'h124]}, 16'h0042);
      chk("cursor_kept", {5'h0, caddr}, 16'h0123);
      setr(vact_pkg::REG_XFER_OPT, 8'h00);
      setr(vact_pkg::REG_CURSOR_LOW, 8'h40);
      setr(vact_pkg::REG_CHAR_PORT, 8'h11);
      wait_done();
      wr(1'b0, 8'h22);
      wait_done();
      chk("mem_no_inc", {8'h0, u_vact_mem_model.mem[11'h140]}, 16'h0022);
      chk("mem_untouched", {8'h0, u_vact_mem_model.mem[11'h141]}, 16'h00E5);
   endtask
   task automatic t_read();
      logic [7:0] s;
      setr(vact_pkg::REG_XFER_OPT, 8'h80);
      setr(vact_pkg::REG_CURSOR_LOW, 8'h23);
      wr(1'b1, {4'h0, vact_pkg::REG_CHAR_PORT});
      rd(1'b0, s);
      wait_done();
      rd(1'b0, s);
      chk("read_first", {8'h0, s}, 16'h0041);
      wait_done();
      rd(1'b0, s);
      chk("read_next", {8'h0, s}, 16'h0042);
      wait_done();
   endtask
   task automatic t_fill();
      setr(vact_pkg::REG_CURSOR_HIGH, 8'h00);
      setr(vact_pkg::REG_CURSOR_LOW, 8'h20);
      setr(vact_pkg::REG_FILL_END, 8'h03);
      setr(vact_pkg::REG_CHAR_PORT, 8'h2A);
      wait_done();
      for (int a = 32; a < 48; a++) begin
         chk("fill_mem", {8'h0, u_vact_mem_model.mem[a]}, 16'h002A);
      end
      chk("fill_end_kept", {8'h0, u_vact_mem_model.mem[48]}, 16'h00E5);
      chk("fill_cursor", {5'h0, caddr}, 16'h0020);
      chk("stray_xfer", stray[15:0], 16'h0000);
   endtask
   // Verdict and end of run
   task automatic complete_run();
      if (bad_count == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #200us;
      bad_count++;
      complete_run();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      sel = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      db = 8'h00;
      blank = 1'b0;
      dch = 8'h00;
      {fd, gd, ul, cur, srow} = 5'h00;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_pixel();
      t_write();
      t_read();
      t_fill();
      complete_run();
   end
endmodule
